// [logic/mscr_regs.sv]
// Functional notes
// - Start-up bit 15 is reserved, always reads zero, writes are dropped.
// - Start-up bit 14 selects fast (0) or slow (1) acceleration table.
// - Bits 13:11 hold second-order acceleration; code 111 means no acceleration.
// - Slow range second-order codes roughly halve per step down to zero.
// - Bits 10:8 hold first-order acceleration code, fast table 76 to 0.3 Hz/s.
// - Slow range first-order codes run 4.8 Hz/s down to 0.019 Hz/s.
// - Handover low range is n times 0.8 Hz; zero is not applicable.
// - Handover high range is (n + 1) times 12.8 Hz.
// - Bits 2:0 select alignment time from 5.3 s down to 0.04 s.
// - Protection register resets to zero, all fields read/write.
// - Start-up register lives at address 0x93 and resets to zero.
// - Soft limit zero disables it, otherwise value times 0.2 A.
// - Hard limit 0.4 A steps in range 1, four fixed levels in range 0.
`timescale 1ns/1ps
`include "mscr_defs.svh"
module mscr_regs
  import mscr_pkg::*;
(
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          rstn,
  // Register port.
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  output logic               reg_rvalid,
  // Configuration towards the motor logic.
  output mscr_startup_s      startup_cfg,
  output mscr_protect_s      protect_cfg,
  output mscr_decoded_s      decoded_cfg
);

  logic [15:0]   startup_reg;
  logic [15:0]   startup_next;
  logic [15:0]   protect_reg;
  logic [15:0]   protect_next;
  logic [15:0]   rdata_reg;
  logic [15:0]   rdata_next;
  logic          rvalid_reg;
  logic          rvalid_next;
  mscr_decoded_s dec_reg;
  mscr_decoded_s dec_next;

  // Alignment time in milliseconds for each code.
  function automatic logic [12:0] align_ms_f(input logic [2:0] code);
    unique case (code)
      3'h0: align_ms_f = 13'h14B4;
      3'h1: align_ms_f = 13'h0A8C;
      3'h2: align_ms_f = 13'h0514;
      3'h3: align_ms_f = 13'h029E;
      3'h4: align_ms_f = 13'h014A;
      3'h5: align_ms_f = 13'h00A0;
      3'h6: align_ms_f = 13'h0050;
      3'h7: align_ms_f = 13'h0028;
    endcase
  endfunction : align_ms_f

  // Hard limit in tenths of an ampere; range 0 ignores the top code bit.
  function automatic logic [5:0] hard_dA_f(input logic rng, input logic [2:0] code);
    logic [5:0] v;
    v = 6'h00;
    if (rng) begin
      v = {1'b0, code, 2'b00} + 6'h04;
    end else begin
      unique case (code[1:0])
        2'h0: v = 6'h19;
        2'h1: v = 6'h13;
        2'h2: v = 6'h0F;
        2'h3: v = 6'h09;
      endcase
    end
    hard_dA_f = v;
  endfunction : hard_dA_f

  // Register writes; the reserved bit is masked so it can never be set.
  always_comb begin
    startup_next = startup_reg;
    protect_next = protect_reg;
    if (reg_wr && reg_addr == `MSCR_ADDR_STARTUP) begin
      startup_next = reg_wdata & `MSCR_SU_WMASK;
    end
    if (reg_wr && reg_addr == `MSCR_ADDR_PROTECT) begin
      protect_next = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      startup_reg <= `MSCR_RST_STARTUP;
      protect_reg <= `MSCR_RST_PROTECT;
    end else begin
      startup_reg <= startup_next;
      protect_reg <= protect_next;
    end
  end

  // Read data is registered; unmapped addresses answer zero.
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `MSCR_ADDR_STARTUP: rdata_next = startup_reg & `MSCR_SU_WMASK;
        `MSCR_ADDR_PROTECT: rdata_next = protect_reg;
        default:            rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Decode of the stored codes into physical units, one cycle behind the
  // registers so that long decode paths do not reach the write port.
  always_comb begin
    logic [4:0] thr;
    logic [3:0] sw;
    thr      = startup_reg[`MSCR_SU_THR_HI:`MSCR_SU_THR_LO];
    sw       = protect_reg[`MSCR_PL_SW_HI:`MSCR_PL_SW_LO];
    dec_next = '0;
    // Steps of 0.8 Hz; the high range is (n + 1) times 16 such steps.
    if (thr[4]) begin
      dec_next.handover_steps = {4'h0, {1'b0, thr[3:0]} + 5'h01} * `MSCR_THR_HI_STEPS;
      dec_next.handover_valid = 1'b1;
    end else begin
      dec_next.handover_steps = {5'h00, thr[3:0]};
      dec_next.handover_valid = (thr[3:0] != 4'h0);
    end
    dec_next.align_ms         = align_ms_f(startup_reg[`MSCR_SU_ALN_HI:`MSCR_SU_ALN_LO]);
    dec_next.soft_limit_on    = (sw != 4'h0);
    dec_next.soft_limit_steps = sw;
    dec_next.hard_limit_dA    = hard_dA_f(protect_reg[`MSCR_PL_RNG],
                                          protect_reg[`MSCR_PL_HW_HI:`MSCR_PL_HW_LO]);
    // The thermal cap values are 1.0, 1.6 and 2.0 A; zero means no cap.
    unique case (protect_reg[`MSCR_PL_OT_HI:`MSCR_PL_OT_LO])
      2'h0: dec_next.thermal_cap_dA = 5'h00;
      2'h1: dec_next.thermal_cap_dA = 5'h0A;
      2'h2: dec_next.thermal_cap_dA = 5'h10;
      2'h3: dec_next.thermal_cap_dA = 5'h14;
    endcase
    // Code 111 is zero acceleration in both tables.
    dec_next.accel2_zero = (startup_reg[`MSCR_SU_ACC2_HI:`MSCR_SU_ACC2_LO] == 3'h7);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  // Field outputs come straight from the stored flops. The range bit travels
  // with both codes; the consumer picks the fast or slow table from it.
  assign startup_cfg.accel_range_select         = startup_reg[`MSCR_SU_RANGE];
  assign startup_cfg.startup_accel_second_order = startup_reg[`MSCR_SU_ACC2_HI:`MSCR_SU_ACC2_LO];
  assign startup_cfg.startup_accel_first_order  = startup_reg[`MSCR_SU_ACC1_HI:`MSCR_SU_ACC1_LO];
  assign startup_cfg.loop_handover_threshold    = startup_reg[`MSCR_SU_THR_HI:`MSCR_SU_THR_LO];
  assign startup_cfg.alignment_duration         = startup_reg[`MSCR_SU_ALN_HI:`MSCR_SU_ALN_LO];
  assign protect_cfg.thermal_current_cap        = protect_reg[`MSCR_PL_OT_HI:`MSCR_PL_OT_LO];
  assign protect_cfg.lock_detect_enable         = protect_reg[`MSCR_PL_LOCK_HI:`MSCR_PL_LOCK_LO];
  assign protect_cfg.soft_current_limit         = protect_reg[`MSCR_PL_SW_HI:`MSCR_PL_SW_LO];
  assign protect_cfg.hard_current_limit         = protect_reg[`MSCR_PL_HW_HI:`MSCR_PL_HW_LO];
  assign protect_cfg.limit_range_select         = protect_reg[`MSCR_PL_RNG];
  assign decoded_cfg = dec_reg;
  assign reg_rdata   = rdata_reg;
  assign reg_rvalid  = rvalid_reg;

  // Checks on the bank behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  rsvd_reads_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `MSCR_ADDR_STARTUP |-> !reg_rdata[15])
    else $error("Reserved start-up bit read as one.");

  range_write_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_STARTUP |=> startup_cfg.accel_range_select == $past(reg_wdata[14]))
    else $error("Range select did not take the written value.");

  accel_codes_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_STARTUP
    |=> {startup_cfg.startup_accel_second_order, startup_cfg.startup_accel_first_order}
        == $past(reg_wdata[13:8]))
    else $error("Acceleration codes wrong after write.");

  accel_zero_a: assert property (
    startup_cfg.startup_accel_second_order == 3'h7 |=> decoded_cfg.accel2_zero)
    else $error("Second-order code 111 not flagged as zero.");

  thr_low_a: assert property (
    !startup_cfg.loop_handover_threshold[4]
    |=> decoded_cfg.handover_steps == {5'h00, $past(startup_cfg.loop_handover_threshold[3:0])}
        && decoded_cfg.handover_valid == ($past(startup_cfg.loop_handover_threshold) != 5'h00))
    else $error("Low handover range decoded wrong.");

  thr_high_a: assert property (
    startup_cfg.loop_handover_threshold == 5'h1F |=> decoded_cfg.handover_steps == 9'h100)
    else $error("Top handover code is not 204.8 Hz.");

  align_long_a: assert property (
    startup_cfg.alignment_duration == 3'h0 |=> decoded_cfg.align_ms == 13'h14B4)
    else $error("Alignment code 000 is not 5.3 s.");

  other_addr_a: assert property (
    !(reg_wr && (reg_addr == `MSCR_ADDR_STARTUP || reg_addr == `MSCR_ADDR_PROTECT))
    |=> $stable(startup_reg) && $stable(protect_reg))
    else $error("Register changed without a write to its address.");

  prot_write_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_PROTECT |=> protect_cfg == $past(reg_wdata))
    else $error("Protection register did not take the write.");

  soft_off_a: assert property (
    protect_cfg.soft_current_limit == 4'h0 |=> !decoded_cfg.soft_limit_on)
    else $error("Soft limit enabled at code zero.");

  hard_lvl_a: assert property (
    protect_cfg.limit_range_select && protect_cfg.hard_current_limit == 3'h7
    |=> decoded_cfg.hard_limit_dA == 6'h20)
    else $error("Hard limit top code is not 3.2 A.");

  readback_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_PROTECT ##1 reg_rd && reg_addr == `MSCR_ADDR_PROTECT && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2) && reg_rvalid)
    else $error("Read-back differs from last write.");

  // Read port checks: the valid strobe mirrors the read strobe one cycle late.
  rvalid_set_a: assert property (
    reg_rd |=> reg_rvalid)
    else $error("Read strobe gave no valid pulse.");

  rvalid_clear_a: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("Valid pulse without a read strobe.");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read.");

  unmapped_zero_a: assert property (
    reg_rd && reg_addr != `MSCR_ADDR_STARTUP && reg_addr != `MSCR_ADDR_PROTECT
    |=> reg_rdata == 16'h0000)
    else $error("Unmapped read did not answer zero.");

  // Start-up register checks; a read right after a write must see the new codes.
  rsvd_flop_zero_a: assert property (
    !startup_reg[15])
    else $error("Reserved start-up bit stored as one.");

  su_write_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_STARTUP |=> startup_cfg == $past(reg_wdata[14:0]))
    else $error("Start-up register did not take the write.");

  su_readback_a: assert property (
    reg_wr && reg_addr == `MSCR_ADDR_STARTUP ##1 reg_rd && reg_addr == `MSCR_ADDR_STARTUP && !reg_wr
    |=> reg_rdata == {1'b0, $past(reg_wdata[14:0], 2)} && reg_rvalid)
    else $error("Start-up read-back differs from last write.");

  accel_nonzero_a: assert property (
    startup_cfg.startup_accel_second_order != 3'h7 |=> !decoded_cfg.accel2_zero)
    else $error("Nonzero second-order code flagged as zero.");

  // Decode checks at table end points, plus soft limit steps and thermal cap code 10.
  thr_step_a: assert property (
    startup_cfg.loop_handover_threshold == 5'h10
    |=> decoded_cfg.handover_steps == 9'h010 && decoded_cfg.handover_valid)
    else $error("Lowest high-range handover code is not 12.8 Hz.");

  align_short_a: assert property (
    startup_cfg.alignment_duration == 3'h7 |=> decoded_cfg.align_ms == 13'h0028)
    else $error("Alignment code 111 is not 0.04 s.");

  soft_on_a: assert property (
    protect_cfg.soft_current_limit != 4'h0
    |=> decoded_cfg.soft_limit_on && decoded_cfg.soft_limit_steps == $past(protect_cfg.soft_current_limit))
    else $error("Soft limit steps do not follow the code.");

  hard_range0_a: assert property (
    !protect_cfg.limit_range_select && protect_cfg.hard_current_limit[1:0] == 2'h3
    |=> decoded_cfg.hard_limit_dA == 6'h09)
    else $error("Range 0 hard limit code x11 is not 0.9 A.");

  thermal_cap_a: assert property (
    protect_cfg.thermal_current_cap == 2'h2 |=> decoded_cfg.thermal_cap_dA == 5'h10)
    else $error("Thermal cap code 10 is not 1.6 A.");

  slow_range_c:  cover property (reg_wr && reg_addr == `MSCR_ADDR_STARTUP && reg_wdata[14]);
  high_thr_c:    cover property (startup_cfg.loop_handover_threshold[4]);
  range0_hard_c: cover property (!protect_cfg.limit_range_select && protect_cfg.hard_current_limit[2]);
  rd_after_wr_c: cover property (reg_wr ##1 reg_rd);
  unmapped_rd_c: cover property (reg_rd && reg_addr != `MSCR_ADDR_STARTUP && reg_addr != `MSCR_ADDR_PROTECT);

endmodule : mscr_regs

// [inc/mscr_defs.svh]
`ifndef MSCR_DEFS_SVH
`define MSCR_DEFS_SVH
// Register addresses on the register port.
`define MSCR_ADDR_STARTUP   8'h93
`define MSCR_ADDR_PROTECT   8'h94
// Reset values.
`define MSCR_RST_STARTUP    16'h0000
`define MSCR_RST_PROTECT    16'h0000
// Start-up profile field positions.
`define MSCR_SU_RSVD        15
`define MSCR_SU_RANGE       14
`define MSCR_SU_ACC2_HI     13
`define MSCR_SU_ACC2_LO     11
`define MSCR_SU_ACC1_HI     10
`define MSCR_SU_ACC1_LO     8
`define MSCR_SU_THR_HI      7
`define MSCR_SU_THR_LO      3
`define MSCR_SU_ALN_HI      2
`define MSCR_SU_ALN_LO      0
// Protection-limit field positions.
`define MSCR_PL_OT_HI       15
`define MSCR_PL_OT_LO       14
`define MSCR_PL_LOCK_HI     13
`define MSCR_PL_LOCK_LO     8
`define MSCR_PL_SW_HI       7
`define MSCR_PL_SW_LO       4
`define MSCR_PL_HW_HI       3
`define MSCR_PL_HW_LO       1
`define MSCR_PL_RNG         0
// Writable mask of the start-up register; the reserved bit is excluded.
`define MSCR_SU_WMASK       16'h7FFF
// High handover range is (n + 1) times this many low-range steps.
`define MSCR_THR_HI_STEPS   9'h010
`endif

// [inc/mscr_pkg.sv]
package mscr_pkg;
  // Start-up profile fields as seen by the commutation logic.
  typedef struct packed {
    logic       accel_range_select;
    logic [2:0] startup_accel_second_order;
    logic [2:0] startup_accel_first_order;
    logic [4:0] loop_handover_threshold;
    logic [2:0] alignment_duration;
  } mscr_startup_s;
  // Protection-limit fields.
  typedef struct packed {
    logic [1:0] thermal_current_cap;
    logic [5:0] lock_detect_enable;
    logic [3:0] soft_current_limit;
    logic [2:0] hard_current_limit;
    logic       limit_range_select;
  } mscr_protect_s;
  // Decoded physical values.
  typedef struct packed {
    logic        handover_valid;
    logic [8:0]  handover_steps;
    logic [12:0] align_ms;
    logic        soft_limit_on;
    logic [3:0]  soft_limit_steps;
    logic [5:0]  hard_limit_dA;
    logic [4:0]  thermal_cap_dA;
    logic        accel2_zero;
  } mscr_decoded_s;
endpackage : mscr_pkg

// [verif/mscr_tb.sv]
`timescale 1ns/1ps
`include "mscr_defs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb
  import mscr_pkg::*;
;
  // Alignment times in ms and fixed current levels in 0.1 A, indexed by code.
  localparam logic [12:0] ALN_MS [8] = '{13'h14B4, 13'h0A8C, 13'h0514, 13'h029E,
                                         13'h014A, 13'h00A0, 13'h0050, 13'h0028};
  localparam logic [5:0]  HW_LO [4]  = '{6'h19, 6'h13, 6'h0F, 6'h09};
  localparam logic [4:0]  OT_DA [4]  = '{5'h00, 5'h0A, 5'h10, 5'h14};
  logic          mclk;
  logic          rstn;
  logic [7:0]    reg_addr;
  logic          reg_wr;
  logic [15:0]   reg_wdata;
  logic          reg_rd;
  logic [15:0]   reg_rdata;
  logic          reg_rvalid;
  mscr_startup_s startup_cfg;
  mscr_protect_s protect_cfg;
  mscr_decoded_s decoded_cfg;
  logic [15:0]   su_m;
  logic [15:0]   pl_m;
  int            err_total;
  int            samples_checked;
  // Device under test.
  mscr_regs dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
                 .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .startup_cfg(startup_cfg),
                 .protect_cfg(protect_cfg), .decoded_cfg(decoded_cfg));
  // Free-running 50 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Expected read value; unmapped places read zero.
  function automatic logic [15:0] model_rd(input logic [7:0] a);
    return (a == `MSCR_ADDR_STARTUP) ? su_m : (a == `MSCR_ADDR_PROTECT) ? pl_m : 16'h0000;
  endfunction : model_rd
  // Expected decode worked out from the field tables.
  function automatic mscr_decoded_s exp_dec(input logic [15:0] su, input logic [15:0] pl);
    mscr_decoded_s d;
    d.handover_valid   = (su[7:3] != 5'h00);
    d.handover_steps   = su[7] ? ({5'h00, su[6:3]} + 9'h001) * 9'h010 : {5'h00, su[6:3]};
    d.align_ms         = ALN_MS[su[2:0]];
    d.soft_limit_on    = (pl[7:4] != 4'h0);
    d.soft_limit_steps = pl[7:4];
    d.hard_limit_dA    = pl[0] ? ({3'h0, pl[3:1]} + 6'h01) * 6'h04 : HW_LO[pl[2:1]];
    d.thermal_cap_dA   = OT_DA[pl[15:14]];
    d.accel2_zero      = (su[13:11] == 3'h7);
    return d;
  endfunction : exp_dec
  // One bus cycle; a read in the same cycle as a write sees the old value.
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    logic [15:0] exp;
    exp       = model_rd(a);
    reg_wr    = w;
    reg_rd    = r;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge mclk);
    @(negedge mclk);
    if (w && a == `MSCR_ADDR_STARTUP) su_m = d & `MSCR_SU_WMASK;
    if (w && a == `MSCR_ADDR_PROTECT) pl_m = d;
    if (r) begin
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, exp)
    end
  endtask : access
  // Idle a cycle, then compare every configuration output with the model.
  task automatic check_cfg();
    mscr_decoded_s e;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    e = exp_dec(su_m, pl_m);
    `CHK(reg_rvalid, 1'b0)
    `CHK(startup_cfg, su_m[14:0])
    `CHK(startup_cfg.accel_range_select, su_m[14])
    `CHK(startup_cfg.startup_accel_second_order, su_m[13:11])
    `CHK(startup_cfg.startup_accel_first_order, su_m[10:8])
    `CHK(protect_cfg, pl_m)
    `CHK({decoded_cfg.handover_valid, decoded_cfg.handover_steps}, {e.handover_valid, e.handover_steps})
    `CHK(decoded_cfg.align_ms, e.align_ms)
    `CHK({decoded_cfg.soft_limit_on, decoded_cfg.soft_limit_steps}, {e.soft_limit_on, e.soft_limit_steps})
    `CHK(decoded_cfg.hard_limit_dA, e.hard_limit_dA)
    `CHK(decoded_cfg.thermal_cap_dA, e.thermal_cap_dA)
    `CHK(decoded_cfg.accel2_zero, e.accel2_zero)
  endtask : check_cfg
  // Single place where the run ends.
  task automatic give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence: reset values, field code walk, random traffic, mid-run reset.
  initial begin
    logic [7:0] a;
    logic [15:0] d;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
    su_m = 16'h0000;
    pl_m = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(49591));
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    check_cfg();
    access(1'b0, 1'b1, `MSCR_ADDR_STARTUP, 16'h0000);
    access(1'b0, 1'b1, `MSCR_ADDR_PROTECT, 16'h0000);
    // Walk all codes of every field but lock detect, which gets codes 0 to 31 only; software keeps the reserved bit clear.
    for (int i = 0; i < 32; i++) begin
      access(1'b1, 1'b0, `MSCR_ADDR_STARTUP, {1'b0, i[0], i[2:0], i[2:0], i[4:0], i[2:0]});
      access(1'b1, 1'b1, `MSCR_ADDR_PROTECT, {i[1:0], i[5:0], i[3:0], i[2:0], i[3]});
      access(1'b0, 1'b1, `MSCR_ADDR_STARTUP, 16'h0000);
      access(1'b1, 1'b1, 8'h95, 16'hFFFF);
      check_cfg();
    end
    // Write then read each register on the very next cycle.
    access(1'b1, 1'b0, `MSCR_ADDR_STARTUP, 16'h5A3C);
    access(1'b0, 1'b1, `MSCR_ADDR_STARTUP, 16'h0000);
    access(1'b1, 1'b0, `MSCR_ADDR_PROTECT, 16'hA5C3);
    access(1'b0, 1'b1, `MSCR_ADDR_PROTECT, 16'h0000);
    // Random traffic, often back to back, including unmapped places.
    for (int i = 0; i < 200; i++) begin
      a = ($urandom % 3 == 0) ? 8'($urandom) : ($urandom % 2 ? `MSCR_ADDR_STARTUP : `MSCR_ADDR_PROTECT);
      d = 16'($urandom);
      if (a == `MSCR_ADDR_STARTUP) d[15] = 1'b0;
      access(1'($urandom), 1'($urandom), a, d);
      if ($urandom % 4 == 0) check_cfg();
    end
    check_cfg();
    // A reset in mid-run must clear both registers at once.
    rstn = 1'b0;
    su_m = 16'h0000;
    pl_m = 16'h0000;
    @(posedge mclk);
    @(negedge mclk);
    `CHK({startup_cfg, protect_cfg, reg_rvalid}, 32'h0000_0000)
    `CHK({reg_rdata, decoded_cfg}, 56'h0)
    rstn = 1'b1;
    check_cfg();
    access(1'b0, 1'b1, `MSCR_ADDR_PROTECT, 16'h0000);
    check_cfg();
    give_verdict();
  end
endmodule : tb
